// >>> bwu_top.sv
`timescale 1ns/10ps
// How it works
// - Cycle condition register clears on power-on reset and hardware standby only.
// - Condition register upper byte reads zero; software writes zero there.
// - Source field 7:6: off, CPU, DMA/transfer controller, or both.
// - Access field 5:4: off, instruction fetch, data access, or both.
// - Direction field 3:2: off, read, write, or both.
// - Size field 1:0: any, byte, word, or longword.
// - Every instruction fetch matches as a word access, even paired fetches.
// - Matching size is the access's own size, not the region bus width.
// - Any of source, access or direction at 00 blocks all breaks.
// - When all enabled conditions agree, raise the break request.
// - Request has level 15; raised only while mask level is 14 or less.
// - At mask level 15 the request stays pending until allowed.
// - Paired fetch compares both instruction addresses; second breaks after first.
// - Fetch break precedes execution; saved PC is the matching fetch address.
// - Deferred fetch break saves the start address of the next instruction.
// - Data break is imprecise; saved PC follows the last executed instruction.
// - Mask bit 1 excludes that address bit; bit 0 must match.
// - Break address is held as two 16-bit halves, upper and lower.
module bwu_top (
  input  wire logic                clock,
  input  wire logic                rst,
  input  wire logic                ce,
  input  wire logic                hw_standby,
  input  wire logic [4:0]          avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  input  wire logic [3:0]          avs_byteenable,
  output logic [31:0]              avs_readdata,
  output logic                     avs_waitrequest,
  input  wire bwu_pkg::bwu_cycle_t cyc,
  input  wire logic [3:0]          interrupt_mask_level,
  input  wire logic [31:0]         cpu_next_pc,
  input  wire logic                brk_ack,
  output logic                     brk_req,
  output logic [3:0]               brk_level,
  output logic                     brk_second,
  output logic                     brk_data,
  output logic [31:0]              brk_pc
);

  bwu_pkg::bwu_state_t s_r;
  bwu_pkg::bwu_state_t s_nxt;
  logic [31:0]         rd_mux;
  logic [31:0]         match_addr;
  logic [31:0]         match_mask;
  logic [31:0]         second_addr;
  logic                hit_first;
  logic                hit_second_raw;
  logic                hit_second;
  logic                any_hit;
  logic                take;

  // ****************************************
  // Address compare, one matcher per instruction slot
  // ****************************************
  assign match_addr  = {s_r.addr_hi, s_r.addr_lo};
  assign match_mask  = {s_r.mask_hi, s_r.mask_lo};
  assign second_addr = cyc.addr + bwu_pkg::INSTR_BYTES;

  bwu_match u_first (
    .cond       (s_r.cond),
    .match_addr (match_addr),
    .mask       (match_mask),
    .cyc        (cyc),
    .cmp_addr   (cyc.addr),
    .hit        (hit_first)
  );

  bwu_match u_second (
    .cond       (s_r.cond),
    .match_addr (match_addr),
    .mask       (match_mask),
    .cyc        (cyc),
    .cmp_addr   (second_addr),
    .hit        (hit_second_raw)
  );

  // The second slot only exists on a paired fetch from 32-bit memory
  assign hit_second = hit_second_raw && cyc.dual && cyc.fetch;
  assign any_hit    = hit_first || hit_second;
  assign take       = brk_ack && s_r.req;

  // ****************************************
  // Read data selection
  // ****************************************
  // Unmapped offsets read zero; 16-bit registers sit in the low half
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (avs_address)
      bwu_pkg::OFS_ADDR_HI: rd_mux[15:0] = s_r.addr_hi;
      bwu_pkg::OFS_ADDR_LO: rd_mux[15:0] = s_r.addr_lo;
      bwu_pkg::OFS_MASK_HI: rd_mux[15:0] = s_r.mask_hi;
      bwu_pkg::OFS_MASK_LO: rd_mux[15:0] = s_r.mask_lo;
      bwu_pkg::OFS_COND:    rd_mux[7:0]  = s_r.cond;
      bwu_pkg::OFS_STATUS:
      begin
        rd_mux[bwu_pkg::STS_PEND_BIT]   = s_r.pend;
        rd_mux[bwu_pkg::STS_REQ_BIT]    = s_r.req;
        rd_mux[bwu_pkg::STS_SECOND_BIT] = s_r.second;
        rd_mux[bwu_pkg::STS_DATA_BIT]   = s_r.data_brk;
        rd_mux[bwu_pkg::STS_NEXT_BIT]   = s_r.use_next;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // ****************************************
  // Next state: bus slave and break tracking
  // ****************************************
  always_comb
  begin
    s_nxt = s_r;
    // Avalon slave: answer one cycle after the request is seen
    case (s_r.bst)
      bwu_pkg::BWU_IDLE:
      begin
        s_nxt.busy = 1'b1;
        if (avs_read || avs_write)
        begin
          s_nxt.bst   = bwu_pkg::BWU_ACK;
          s_nxt.busy  = 1'b0;
          s_nxt.rdata = rd_mux;
        end
      end
      bwu_pkg::BWU_ACK:
      begin
        s_nxt.bst  = bwu_pkg::BWU_IDLE;
        s_nxt.busy = 1'b1;
        // Write commits on the edge where waitrequest is seen low
        if (avs_write)
        begin
          case (avs_address)
            bwu_pkg::OFS_ADDR_HI:
            begin
              if (avs_byteenable[1]) s_nxt.addr_hi[15:8] = avs_writedata[15:8];
              if (avs_byteenable[0]) s_nxt.addr_hi[7:0]  = avs_writedata[7:0];
            end
            bwu_pkg::OFS_ADDR_LO:
            begin
              if (avs_byteenable[1]) s_nxt.addr_lo[15:8] = avs_writedata[15:8];
              if (avs_byteenable[0]) s_nxt.addr_lo[7:0]  = avs_writedata[7:0];
            end
            bwu_pkg::OFS_MASK_HI:
            begin
              if (avs_byteenable[1]) s_nxt.mask_hi[15:8] = avs_writedata[15:8];
              if (avs_byteenable[0]) s_nxt.mask_hi[7:0]  = avs_writedata[7:0];
            end
            bwu_pkg::OFS_MASK_LO:
            begin
              if (avs_byteenable[1]) s_nxt.mask_lo[15:8] = avs_writedata[15:8];
              if (avs_byteenable[0]) s_nxt.mask_lo[7:0]  = avs_writedata[7:0];
            end
            // Reserved upper byte is not stored at all
            bwu_pkg::OFS_COND:
            begin
              if (avs_byteenable[0]) s_nxt.cond = avs_writedata[7:0];
            end
            default: s_nxt.cond = s_r.cond;
          endcase
        end
      end
      default:
      begin
        s_nxt.bst  = bwu_pkg::BWU_IDLE;
        s_nxt.busy = 1'b1;
      end
    endcase

    // Acceptance by the arbiter retires the pending break
    if (take)
    begin
      s_nxt.pend   = 1'b0;
      s_nxt.second = 1'b0;
      // Imprecise or deferred breaks take the CPU's next address now
      if (s_r.use_next)
        s_nxt.pc = cpu_next_pc;
    end
    // A hit in the accept cycle re-arms; other hits while a break is pending are dropped.
    // Later register writes cannot cancel a latched second-slot break.
    if ((!s_r.pend || take) && any_hit)
    begin
      s_nxt.pend     = 1'b1;
      s_nxt.second   = !hit_first;
      s_nxt.data_brk = !cyc.fetch;
      s_nxt.use_next = !cyc.fetch || cyc.defer;
      s_nxt.pc       = hit_first ? cyc.addr : second_addr;
    end
    // Hardware standby clears registers and pending state like power-on, but keeps pc and data flag; software standby is not seen here
    if (hw_standby)
    begin
      s_nxt.addr_hi  = bwu_pkg::HALF_RST;
      s_nxt.addr_lo  = bwu_pkg::HALF_RST;
      s_nxt.mask_hi  = bwu_pkg::HALF_RST;
      s_nxt.mask_lo  = bwu_pkg::HALF_RST;
      s_nxt.cond     = bwu_pkg::COND_RST;
      s_nxt.pend     = 1'b0;
      s_nxt.second   = 1'b0;
      s_nxt.use_next = 1'b0;
    end
    // Pending stays put while the mask level blocks it
    s_nxt.req   = s_nxt.pend && (interrupt_mask_level <= bwu_pkg::MASK_LEVEL_MAX);
    s_nxt.level = bwu_pkg::BRK_LEVEL;
  end

  // ****************************************
  // State register
  // ****************************************
  // Clock enable low freezes everything, bus handshake included
  always_ff @(posedge clock)
  begin
    if (rst)
      s_r <= bwu_pkg::STATE_RST;
    else if (ce)
      s_r <= s_nxt;
  end

  // Outputs straight from the state register
  assign avs_readdata    = s_r.rdata;
  assign avs_waitrequest = s_r.busy;
  assign brk_req         = s_r.req;
  assign brk_level       = s_r.level;
  assign brk_second      = s_r.second;
  assign brk_data        = s_r.data_brk;
  assign brk_pc          = s_r.pc;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  sequence s_new_hit;
    ce && !hw_standby && (!s_r.pend || take) && any_hit;
  endsequence

  sequence s_fetch_first;
    s_new_hit and (hit_first && cyc.fetch && !cyc.defer);
  endsequence

  sequence s_second_only;
    s_new_hit and (!hit_first && hit_second && !cyc.defer);
  endsequence

  property p_standby_clear;
    (ce && hw_standby) |=> (s_r.cond == 8'h00) && (match_addr == 32'h0) && !brk_req;
  endproperty
  a_standby_clear: assert property (p_standby_clear) else $error("standby did not clear");

  property p_rsv_zero;
    (!avs_waitrequest && avs_read && avs_address == bwu_pkg::OFS_COND) |->
      (avs_readdata[31:8] == 24'h000000);
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bits read nonzero");

  property p_group_off;
    (ce && !s_r.pend && (s_r.cond[7:6] == 2'h0 || s_r.cond[5:4] == 2'h0 ||
      s_r.cond[3:2] == 2'h0)) |=> !s_r.pend;
  endproperty
  a_group_off: assert property (p_group_off) else $error("break raised while disabled");

  property p_hit_sets;
    s_new_hit |=> s_r.pend;
  endproperty
  a_hit_sets: assert property (p_hit_sets) else $error("match did not set pending");

  property p_masked;
    (ce && interrupt_mask_level == 4'hF) |=> !brk_req && (brk_level == 4'hF);
  endproperty
  a_masked: assert property (p_masked) else $error("request raised at mask 15");

  property p_hold;
    (ce && s_r.pend && !take && !hw_standby) |=> s_r.pend [*1] ##0
      (brk_req == ($past(interrupt_mask_level) <= 4'hE));
  endproperty
  a_hold: assert property (p_hold) else $error("pending lost or request wrong");

  property p_fetch_pc;
    s_fetch_first |=> (brk_pc == $past(cyc.addr)) && !brk_second && !s_r.use_next;
  endproperty
  a_fetch_pc: assert property (p_fetch_pc) else $error("fetch break saved wrong pc");

  property p_second_pc;
    s_second_only |=> brk_second && (brk_pc == $past(cyc.addr) + 32'h2);
  endproperty
  a_second_pc: assert property (p_second_pc) else $error("second slot break wrong");

  property p_next_pc;
    (ce && take && s_r.use_next && !any_hit) |=> (brk_pc == $past(cpu_next_pc)) && !s_r.pend;
  endproperty
  a_next_pc: assert property (p_next_pc) else $error("deferred pc not taken");

  property p_bus_answer;
    (ce && s_r.bst == bwu_pkg::BWU_IDLE && (avs_read || avs_write)) |=> !avs_waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("slave did not answer");

endmodule

// >>> bwu_pkg.sv
package bwu_pkg;

  // ****************************************
  // Register map (byte addresses, one word each)
  // ****************************************
  localparam logic [4:0] OFS_ADDR_HI = 5'h00;
  localparam logic [4:0] OFS_ADDR_LO = 5'h04;
  localparam logic [4:0] OFS_MASK_HI = 5'h08;
  localparam logic [4:0] OFS_MASK_LO = 5'h0C;
  localparam logic [4:0] OFS_COND    = 5'h10;
  localparam logic [4:0] OFS_STATUS  = 5'h14;

  // ****************************************
  // Condition field positions and codes
  // ****************************************
  localparam int SRC_CPU_BIT    = 6;
  localparam int SRC_DMA_BIT    = 7;
  localparam int KIND_FETCH_BIT = 4;
  localparam int KIND_DATA_BIT  = 5;
  localparam int DIR_RD_BIT     = 2;
  localparam int DIR_WR_BIT     = 3;
  localparam int SIZE_LSB       = 0;
  localparam int SIZE_MSB       = 1;

  localparam logic [1:0] SIZE_ANY  = 2'h0;
  localparam logic [1:0] SIZE_BYTE = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  localparam logic [1:0] SIZE_LONG = 2'h3;

  // Status word bit positions
  localparam int STS_PEND_BIT   = 0;
  localparam int STS_REQ_BIT    = 1;
  localparam int STS_SECOND_BIT = 2;
  localparam int STS_DATA_BIT   = 3;
  localparam int STS_NEXT_BIT   = 4;

  // ****************************************
  // Reset values and fixed figures
  // ****************************************
  localparam logic [7:0]  COND_RST       = 8'h00;
  localparam logic [15:0] HALF_RST       = 16'h0000;
  localparam logic [31:0] WORD_RST       = 32'h0000_0000;
  localparam logic [3:0]  BRK_LEVEL      = 4'hF;
  localparam logic [3:0]  MASK_LEVEL_MAX = 4'hE;
  localparam logic [31:0] INSTR_BYTES    = 32'h0000_0002;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    logic        dma;
    logic        fetch;
    logic        write;
    logic [1:0]  size;
    logic        dual;
    logic        defer;
  } bwu_cycle_t;

  typedef enum logic [1:0] {
    BWU_IDLE = 2'b01,
    BWU_ACK  = 2'b10
  } bwu_bus_st_t;

  typedef struct packed {
    bwu_bus_st_t bst;
    logic        busy;
    logic [31:0] rdata;
    logic [15:0] addr_hi;
    logic [15:0] addr_lo;
    logic [15:0] mask_hi;
    logic [15:0] mask_lo;
    logic [7:0]  cond;
    logic        pend;
    logic        req;
    logic        second;
    logic        data_brk;
    logic        use_next;
    logic [31:0] pc;
    logic [3:0]  level;
  } bwu_state_t;

  localparam bwu_state_t STATE_RST = '{
    bst: BWU_IDLE, busy: 1'b1, rdata: WORD_RST,
    addr_hi: HALF_RST, addr_lo: HALF_RST, mask_hi: HALF_RST, mask_lo: HALF_RST,
    cond: COND_RST, pend: 1'b0, req: 1'b0, second: 1'b0, data_brk: 1'b0,
    use_next: 1'b0, pc: WORD_RST, level: BRK_LEVEL};

endpackage

// >>> bwu_match.sv
`timescale 1ns/10ps
module bwu_match (
  input  wire logic [7:0]         cond,
  input  wire logic [31:0]        match_addr,
  input  wire logic [31:0]        mask,
  input  wire bwu_pkg::bwu_cycle_t cyc,
  input  wire logic [31:0]        cmp_addr,
  output logic                    hit
);

  logic       src_ok;
  logic       kind_ok;
  logic       dir_ok;
  logic       size_ok;
  logic       addr_ok;
  logic [1:0] eff_size;
  logic [1:0] size_sel;

  // ****************************************
  // Per-field agreement
  // ****************************************
  // A source, access or direction field of 00 has neither bit set, so it can never agree
  assign src_ok  = cyc.dma ? cond[bwu_pkg::SRC_DMA_BIT] : cond[bwu_pkg::SRC_CPU_BIT];
  assign kind_ok = cyc.fetch ? cond[bwu_pkg::KIND_FETCH_BIT]
                             : cond[bwu_pkg::KIND_DATA_BIT];
  assign dir_ok  = cyc.write ? cond[bwu_pkg::DIR_WR_BIT] : cond[bwu_pkg::DIR_RD_BIT];

  // Size is the access's own size; a fetch always counts as a word
  assign size_sel = cond[bwu_pkg::SIZE_MSB:bwu_pkg::SIZE_LSB];
  assign eff_size = cyc.fetch ? bwu_pkg::SIZE_WORD : cyc.size;
  assign size_ok  = (size_sel == bwu_pkg::SIZE_ANY) || (size_sel == eff_size);

  // Mask bit 1 drops that address bit from the compare
  assign addr_ok = ((cmp_addr ^ match_addr) & ~mask) == 32'h0000_0000;

  // All conditions in the same bus cycle
  assign hit = cyc.valid && src_ok && kind_ok && dir_ok && size_ok && addr_ok;

endmodule

// >>> bwu_arbiter_model.sv
`timescale 1ns/10ps
// ****************************************
// Interrupt arbiter and CPU stand-in
// ****************************************
module bwu_arbiter_model (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       brk_req,
  input  wire logic [3:0] interrupt_mask_level,
  input  wire logic       hold,
  output logic            brk_ack
);
  // One-cycle accept pulse; hold models a CPU slow to reach an accept point
  always_ff @(posedge clock)
  begin
    if (rst)
      brk_ack <= 1'b0;
    else
      brk_ack <= brk_req && !brk_ack && !hold && (interrupt_mask_level <= 4'hE);
  end
endmodule

// >>> tb_top.sv
`timescale 1ns/10ps
`define CHK(g, e) \
  begin \
    check_count++; \
    if ((g) !== (e)) \
    begin \
      mismatches++; \
      $display("ERROR t=%0t got %h expected %h", $time, (g), (e)); \
    end \
  end
// ****************************************
// Bench top
// ****************************************
module tb_top;
  localparam logic [31:0] NXT = 32'h00002000;
  logic                clock = 1'b0;
  logic                rst = 1'b1;
  logic                hw_standby = 1'b0;
  logic [4:0]          avs_address = 5'h00;
  logic                avs_read = 1'b0;
  logic                avs_write = 1'b0;
  logic [31:0]         avs_writedata = 32'h00000000;
  logic [31:0]         avs_readdata;
  logic                avs_waitrequest;
  bwu_pkg::bwu_cycle_t cyc = '0;
  logic [3:0]          interrupt_mask_level = 4'h0;
  logic                brk_ack;
  logic                brk_req;
  logic [3:0]          brk_level;
  logic                brk_second;
  logic                brk_data;
  logic [31:0]         brk_pc;
  logic                hold = 1'b1;
  logic [31:0]         rq;
  logic [31:0]         nxt_pc = 32'h00000000;
  int                  mismatches = 0;
  int                  check_count = 0;

  // Clock at 200 MHz
  always #2.5 clock = ~clock;

  // Clock enable and byte lanes tied: freezing is not exercised
  bwu_top i_dut (
    .clock(clock), .rst(rst), .ce(1'b1), .hw_standby(hw_standby),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cyc(cyc),
    .interrupt_mask_level(interrupt_mask_level), .cpu_next_pc(nxt_pc), .brk_ack(brk_ack),
    .brk_req(brk_req), .brk_level(brk_level), .brk_second(brk_second),
    .brk_data(brk_data), .brk_pc(brk_pc)
  );

  bwu_arbiter_model i_arb (
    .clock(clock), .rst(rst), .brk_req(brk_req),
    .interrupt_mask_level(interrupt_mask_level), .hold(hold), .brk_ack(brk_ack)
  );

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // One Avalon access; request held until waitrequest is sampled low
  // No local limit: a slave that never answers is caught by the watchdog
  task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do
      @(posedge clock);
    while (avs_waitrequest !== 1'b0);
    rq = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic rdchk(input logic [4:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h00000000);
    `CHK(rq, e)
  endtask

  // One watched bus cycle; the arbiter is held off while the request is judged.
  // The CPU's next address moves after the hit, so only capture at accept passes.
  task automatic brk(input logic [31:0] a, input logic [6:0] f, input logic er,
                     input logic [31:0] ep, input logic [1:0] ef);
    int n;
    @(posedge clock);
    cyc <= bwu_pkg::bwu_cycle_t'({1'b1, a, f});
    hold <= 1'b1;
    nxt_pc <= 32'h00001000;
    @(posedge clock);
    cyc <= '0;
    #1;
    `CHK(brk_req, er)
    if (er)
    begin
      `CHK({brk_second, brk_data}, ef)
      `CHK(brk_level, bwu_pkg::BRK_LEVEL)
    end
    @(posedge clock);
    hold <= 1'b0;
    nxt_pc <= NXT;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (brk_req !== 1'b0 && n < 20);
    #1;
    `CHK(brk_req, 1'b0)
    if (er)
      `CHK(brk_pc, ep)
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  // Break raised at mask level 15 must wait, then go out at 14
  task automatic pend_chk;
    int n;
    @(posedge clock);
    interrupt_mask_level <= 4'hF;
    hold <= 1'b0;
    cyc <= bwu_pkg::bwu_cycle_t'({1'b1, 32'h00000404, 7'h28});
    @(posedge clock);
    cyc <= '0;
    repeat (3) @(posedge clock);
    #1;
    `CHK(brk_req, 1'b0)
    rdchk(bwu_pkg::OFS_STATUS, 32'h00000001);
    @(posedge clock);
    interrupt_mask_level <= 4'hE;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (brk_req !== 1'b1 && n < 10);
    `CHK(brk_req, 1'b1)
    repeat (4) @(posedge clock);
    interrupt_mask_level <= 4'h0;
  endtask

  // Codes that must never break on a CPU fetch read at the programmed address
  task automatic no_break_codes;
    logic [7:0] tbl [6] = '{8'h14, 8'h44, 8'h50, 8'h94, 8'h58, 8'h55};
    foreach (tbl[i])
    begin
      acc(1'b1, bwu_pkg::OFS_COND, {24'h000000, tbl[i]});
      brk(32'h00000404, 7'h28, 1'b0, 32'h00000000, 2'b00);
    end
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    rdchk(bwu_pkg::OFS_ADDR_HI, 32'h00000000);
    rdchk(bwu_pkg::OFS_ADDR_LO, 32'h00000000);
    rdchk(bwu_pkg::OFS_MASK_HI, 32'h00000000);
    rdchk(bwu_pkg::OFS_MASK_LO, 32'h00000000);
    rdchk(bwu_pkg::OFS_COND, 32'h00000000);
    rdchk(5'h18, 32'h00000000);
    acc(1'b1, bwu_pkg::OFS_COND, 32'h000000FF);
    rdchk(bwu_pkg::OFS_COND, 32'h000000FF);
    acc(1'b1, bwu_pkg::OFS_ADDR_HI, 32'h00000000);
    acc(1'b1, bwu_pkg::OFS_ADDR_LO, 32'h00000404);
    no_break_codes();
    acc(1'b1, bwu_pkg::OFS_COND, 32'h00000054);
    brk(32'h00000404, 7'h28, 1'b1, 32'h00000404, 2'b00);
    brk(32'h00000404, 7'h29, 1'b1, NXT, 2'b00);
    acc(1'b1, bwu_pkg::OFS_COND, 32'h00000056);
    brk(32'h00000404, 7'h2C, 1'b1, 32'h00000404, 2'b00);
    acc(1'b1, bwu_pkg::OFS_ADDR_LO, 32'h00000406);
    brk(32'h00000404, 7'h2A, 1'b1, 32'h00000406, 2'b10);
    acc(1'b1, bwu_pkg::OFS_ADDR_HI, 32'h00000012);
    acc(1'b1, bwu_pkg::OFS_ADDR_LO, 32'h00003456);
    acc(1'b1, bwu_pkg::OFS_COND, 32'h0000006A);
    brk(32'h00123456, 7'h18, 1'b1, NXT, 2'b01);
    brk(32'h00123456, 7'h1C, 1'b0, NXT, 2'b01);
    acc(1'b1, bwu_pkg::OFS_COND, 32'h000000A7);
    brk(32'h00123456, 7'h4C, 1'b1, NXT, 2'b01);
    brk(32'h00123456, 7'h0C, 1'b0, NXT, 2'b01);
    acc(1'b1, bwu_pkg::OFS_COND, 32'h00000065);
    brk(32'h00123456, 7'h04, 1'b1, NXT, 2'b01);
    brk(32'h00123456, 7'h08, 1'b0, NXT, 2'b01);
    acc(1'b1, bwu_pkg::OFS_COND, 32'h000000FC);
    acc(1'b1, bwu_pkg::OFS_ADDR_LO, 32'h00003400);
    acc(1'b1, bwu_pkg::OFS_MASK_LO, 32'h000000FF);
    brk(32'h001234AB, 7'h54, 1'b1, NXT, 2'b01);
    brk(32'h001235AB, 7'h54, 1'b0, NXT, 2'b01);
    acc(1'b1, bwu_pkg::OFS_COND, 32'h00000054);
    acc(1'b1, bwu_pkg::OFS_ADDR_HI, 32'h00000000);
    acc(1'b1, bwu_pkg::OFS_ADDR_LO, 32'h00000404);
    acc(1'b1, bwu_pkg::OFS_MASK_LO, 32'h00000000);
    pend_chk();
    @(posedge clock);
    hw_standby <= 1'b1;
    @(posedge clock);
    hw_standby <= 1'b0;
    rdchk(bwu_pkg::OFS_COND, 32'h00000000);
    rdchk(bwu_pkg::OFS_ADDR_LO, 32'h00000000);
    results();
  end

  // Watchdog: the whole sequence needs well under a thousand cycles
  initial
  begin
    repeat (20000) @(posedge clock);
    mismatches++;
    results();
  end
endmodule
